// file: hw/bus_sizer_pkg.sv
// Package for the dynamic bus sizing and operand alignment block
// Assumes one system clock and an active-low asynchronous reset
package bus_sizer_pkg;
  localparam int ADDR_W = 24;
  // Remaining-size codes
  typedef enum logic [1:0] {
    LEN_LONG  = 2'b00,
    LEN_BYTE  = 2'b01,
    LEN_WORD  = 2'b10,
    LEN_THREE = 2'b11
  } len_t;
  // Acknowledge codes {hi, lo}, pins already synchronised
  localparam logic [1:0] ACK_WAIT  = 2'b11;
  localparam logic [1:0] ACK_PORT8 = 2'b10;
  localparam logic [1:0] ACK_PORT16 = 2'b01;
  localparam logic [1:0] ACK_RSVD  = 2'b00;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [1:0] CNT_BYTE = 2'h1;
  localparam logic [1:0] CNT_WORD = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS  = 2'b01,
    ST_DONE = 2'b10
  } state_t;
  // Operand request from the core side
  typedef struct packed {
    logic                 write;
    len_t                 len;
    logic [ADDR_W-1:0]    addr;
    logic [31:0]          data;
  } req_t;
  // Pin-side cycle outputs
  typedef struct packed {
    logic                 strobe;
    logic                 write;
    len_t                 len;
    logic [ADDR_W-1:0]    addr;
    logic [15:0]          data;
  } cyc_t;
endpackage

// file: hw/bus_sizer.sv
// Dynamic bus sizing: splits operands into 8/16-bit port cycles
// Assumes acknowledge pins arrive asynchronously; core request is synchronous
//
// What this block does
// - Act on wait, 8-bit, 16-bit, reserved acknowledge
// - Long read at 16 bits: latch, run again
// - Long read at 8 bits: four cycles
// - Move maximum; assume 16-bit port first
// - Operand byte 0 is most significant
// - Size code gives bytes still remaining
// - Codes 01 byte, 10 word, 11 three, 00 long
// - Address gives word base plus offset bit
// - Misaligned word or long refused
// - One aligned word per cycle, high first
// - Byte to 16-bit port: lane by offset
// - Wider 16-bit cycles: byte0 high, byte1 low
// - 8-bit cycles: byte0 high lane; low lane copies it only at odd address or byte size
// - Reads take only the operand lane
// - Three-byte code only mid long transfer
// - Long to 8-bit starts 00, offset 0
`timescale 1ns/1ps
module bus_sizer (
  input  wire logic                  REF_CLK,
  input  wire logic                  NRST,
  input  wire logic                  REQ_VALID,
  input  wire bus_sizer_pkg::req_t   REQ,
  output logic                       REQ_READY,
  output logic                       DONE,
  output logic                       ERR_ACK_RSVD,
  output logic                       ERR_MISALIGN,
  output logic [31:0]                RDATA,
  input  wire logic                  ACK_SIZE_HI,
  input  wire logic                  ACK_SIZE_LO,
  output bus_sizer_pkg::cyc_t        CYC,
  input  wire logic [15:0]           DATA_IN,
  output logic                       DATA_OE
);
  bus_sizer_pkg::state_t    state;
  bus_sizer_pkg::state_t    next_state;
  logic [2:0]               sync_hi;
  logic [2:0]               sync_lo;
  logic [1:0]               ack;
  logic [1:0]               ack_prev;
  logic                     ack_ok;
  logic                     write;
  logic                     next_write;
  bus_sizer_pkg::len_t      len;
  bus_sizer_pkg::len_t      next_len;
  logic [bus_sizer_pkg::ADDR_W-1:0] addr;
  logic [bus_sizer_pkg::ADDR_W-1:0] next_addr;
  logic [31:0]              wbuf;
  logic [31:0]              next_wbuf;
  logic [31:0]              rbuf;
  logic [31:0]              next_rbuf;
  logic [31:0]              next_rdata;
  logic                     next_done;
  logic                     next_err_rsvd;
  logic                     next_err_mis;
  logic                     first;
  logic                     next_first;
  logic [15:0]              lanes;
  logic [15:0]              next_lanes;
  logic [7:0]               rbyte;
  logic [1:0]               moved;

  // Acknowledge pins: three flops, change accepted when last two agree
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sync_hi  <= bus_sizer_pkg::SYNC_RESET;
      sync_lo  <= bus_sizer_pkg::SYNC_RESET;
      ack_prev <= bus_sizer_pkg::ACK_WAIT;
    end else begin
      sync_hi  <= {sync_hi[1:0], ACK_SIZE_HI};
      sync_lo  <= {sync_lo[1:0], ACK_SIZE_LO};
      ack_prev <= ack;
    end
  end

  always_comb begin
    ack = ack_prev;
    if (sync_hi[2] == sync_hi[1]) begin
      ack[1] = sync_hi[2];
    end
    if (sync_lo[2] == sync_lo[1]) begin
      ack[0] = sync_lo[2];
    end
  end

  // Only a fresh answer after wait ends the cycle; a stale code from the last cycle does not
  assign ack_ok = (state == bus_sizer_pkg::ST_BUS) && (ack != bus_sizer_pkg::ACK_WAIT)
                  && (ack_prev == bus_sizer_pkg::ACK_WAIT);

  // Lane placement for the pending bytes
  function automatic logic [15:0] place(input bus_sizer_pkg::len_t l, input logic off, input logic [31:0] b);
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = b[31:24];
    b1 = b[23:16];
    if (l == bus_sizer_pkg::LEN_BYTE || off) begin
      place = {b0, b0};
    end else begin
      place = {b0, b1};
    end
  endfunction

  // Bytes moved and read byte chosen from the answered port width
  always_comb begin
    moved = bus_sizer_pkg::CNT_BYTE;
    rbyte = DATA_IN[15:8];
    if (ack == bus_sizer_pkg::ACK_PORT16 || ack == bus_sizer_pkg::ACK_RSVD) begin
      if (len != bus_sizer_pkg::LEN_BYTE && !addr[0]) begin
        moved = bus_sizer_pkg::CNT_WORD;
      end
      if (addr[0]) begin
        rbyte = DATA_IN[7:0];
      end
    end
  end

  always_comb begin
    next_state    = state;
    next_write    = write;
    next_len      = len;
    next_addr     = addr;
    next_wbuf     = wbuf;
    next_rbuf     = rbuf;
    next_rdata    = RDATA;
    next_done     = 1'b0;
    next_err_rsvd = 1'b0;
    next_err_mis  = 1'b0;
    next_first    = first;
    next_lanes    = lanes;
    case (state)
      bus_sizer_pkg::ST_IDLE: begin
        if (REQ_VALID) begin
          if (REQ.addr[0] && REQ.len != bus_sizer_pkg::LEN_BYTE) begin
            next_err_mis = 1'b1;
            next_done    = 1'b1;
          end else if (REQ.len == bus_sizer_pkg::LEN_THREE) begin
            // Three-byte request cannot open an operand
            next_done = 1'b1;
          end else begin
            next_state = bus_sizer_pkg::ST_BUS;
            next_write = REQ.write;
            next_len   = REQ.len;
            next_addr  = REQ.addr;
            next_first = 1'b1;
            // Operand left-justified, byte 0 at the top
            case (REQ.len)
              bus_sizer_pkg::LEN_BYTE:  next_wbuf = {REQ.data[7:0], 24'h000000};
              bus_sizer_pkg::LEN_WORD:  next_wbuf = {REQ.data[15:0], 16'h0000};
              bus_sizer_pkg::LEN_THREE: next_wbuf = {REQ.data[23:0], 8'h00};
              default:                  next_wbuf = REQ.data;
            endcase
            next_rbuf  = 32'h00000000;
            next_lanes = place(REQ.len, REQ.addr[0], next_wbuf);
          end
        end
      end
      bus_sizer_pkg::ST_BUS: begin
        if (ack_ok) begin
          next_first    = 1'b0;
          next_err_rsvd = (ack == bus_sizer_pkg::ACK_RSVD);
          if (moved == bus_sizer_pkg::CNT_WORD) begin
            next_rbuf = {rbuf[15:0], DATA_IN};
            next_wbuf = {wbuf[15:0], 16'h0000};
          end else begin
            next_rbuf = {rbuf[23:0], rbyte};
            next_wbuf = {wbuf[23:0], 8'h00};
          end
          next_addr = addr + {{(bus_sizer_pkg::ADDR_W-2){1'b0}}, moved};
          next_len  = bus_sizer_pkg::len_t'(len - moved);
          if (len == bus_sizer_pkg::len_t'(moved)) begin
            next_state = bus_sizer_pkg::ST_DONE;
            next_rdata = (moved == bus_sizer_pkg::CNT_WORD) ? {rbuf[15:0], DATA_IN} : {rbuf[23:0], rbyte};
          end
          next_lanes = place(next_len, next_addr[0], next_wbuf);
        end
      end
      bus_sizer_pkg::ST_DONE: begin
        next_done  = 1'b1;
        next_state = bus_sizer_pkg::ST_IDLE;
      end
      default: next_state = bus_sizer_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state        <= bus_sizer_pkg::ST_IDLE;
      write        <= 1'b0;
      len          <= bus_sizer_pkg::LEN_LONG;
      addr         <= '0;
      wbuf         <= 32'h00000000;
      rbuf         <= 32'h00000000;
      RDATA        <= 32'h00000000;
      DONE         <= 1'b0;
      ERR_ACK_RSVD <= 1'b0;
      ERR_MISALIGN <= 1'b0;
      first        <= 1'b0;
      lanes        <= 16'h0000;
    end else begin
      state        <= next_state;
      write        <= next_write;
      len          <= next_len;
      addr         <= next_addr;
      wbuf         <= next_wbuf;
      rbuf         <= next_rbuf;
      RDATA        <= next_rdata;
      DONE         <= next_done;
      ERR_ACK_RSVD <= next_err_rsvd;
      ERR_MISALIGN <= next_err_mis;
      first        <= next_first;
      lanes        <= next_lanes;
    end
  end

  assign REQ_READY  = (state == bus_sizer_pkg::ST_IDLE);
  assign CYC.strobe = (state == bus_sizer_pkg::ST_BUS);
  assign CYC.write  = write;
  assign CYC.len    = len;
  assign CYC.addr   = addr;
  assign CYC.data   = lanes;
  assign DATA_OE    = (state == bus_sizer_pkg::ST_BUS) && write;

  // Three-byte code never opens an operand
  property p_three_mid;
    @(posedge REF_CLK) disable iff (!NRST)
      (CYC.strobe && first) |-> (CYC.len != bus_sizer_pkg::LEN_THREE);
  endproperty
  a_three_mid: assert property (p_three_mid) else $error("three-byte code on first cycle");

  property p_wait_holds;
    @(posedge REF_CLK) disable iff (!NRST)
      (CYC.strobe && ack == bus_sizer_pkg::ACK_WAIT) |=> (CYC.strobe && $stable(CYC.addr) && $stable(CYC.len));
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("cycle moved during wait");

  property p_step8;
    @(posedge REF_CLK) disable iff (!NRST)
      (ack_ok && ack == bus_sizer_pkg::ACK_PORT8 && CYC.len != bus_sizer_pkg::LEN_BYTE)
        |=> (CYC.addr == $past(CYC.addr) + 24'h000001);
  endproperty
  a_step8: assert property (p_step8) else $error("8-bit step wrong");

  property p_len8;
    @(posedge REF_CLK) disable iff (!NRST)
      (ack_ok && ack == bus_sizer_pkg::ACK_PORT8 && CYC.len != bus_sizer_pkg::LEN_BYTE)
        |=> (CYC.len == bus_sizer_pkg::len_t'($past(CYC.len) - 2'b01));
  endproperty
  a_len8: assert property (p_len8) else $error("8-bit size code not lowered by one");

  property p_step16;
    @(posedge REF_CLK) disable iff (!NRST)
      (ack_ok && ack != bus_sizer_pkg::ACK_PORT8 && CYC.len != bus_sizer_pkg::LEN_BYTE && !CYC.addr[0])
        |=> (CYC.addr == $past(CYC.addr) + 24'h000002);
  endproperty
  a_step16: assert property (p_step16) else $error("16-bit step wrong");

  property p_stale;
    @(posedge REF_CLK) disable iff (!NRST)
      (CYC.strobe && ack_prev != bus_sizer_pkg::ACK_WAIT) |=> (CYC.strobe && $stable(CYC.addr));
  endproperty
  a_stale: assert property (p_stale) else $error("cycle ended by stale acknowledge");

  property p_byte_last;
    @(posedge REF_CLK) disable iff (!NRST)
      (ack_ok && CYC.len == bus_sizer_pkg::LEN_BYTE) |=> (!CYC.strobe ##1 DONE);
  endproperty
  a_byte_last: assert property (p_byte_last) else $error("operand not ended after last byte");

  property p_long16;
    @(posedge REF_CLK) disable iff (!NRST)
      (ack_ok && CYC.len == bus_sizer_pkg::LEN_LONG && ack == bus_sizer_pkg::ACK_PORT16)
        |=> (CYC.strobe && CYC.len == bus_sizer_pkg::LEN_WORD);
  endproperty
  a_long16: assert property (p_long16) else $error("long at 16 bits not followed by word");

  property p_mis;
    @(posedge REF_CLK) disable iff (!NRST)
      (REQ_READY && REQ_VALID && REQ.addr[0] && REQ.len != bus_sizer_pkg::LEN_BYTE) |=> (ERR_MISALIGN && !CYC.strobe);
  endproperty
  a_mis: assert property (p_mis) else $error("misaligned operand started");

  property p_rsvd;
    @(posedge REF_CLK) disable iff (!NRST)
      (ack_ok && ack == bus_sizer_pkg::ACK_RSVD) |=> ERR_ACK_RSVD;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code not flagged");

  property p_lane_hi;
    @(posedge REF_CLK) disable iff (!NRST)
      (CYC.strobe && CYC.write) |-> (CYC.data[15:8] == wbuf[31:24]);
  endproperty
  a_lane_hi: assert property (p_lane_hi) else $error("byte 0 not on upper lane");

  property p_lane_lo;
    @(posedge REF_CLK) disable iff (!NRST)
      (CYC.strobe && CYC.write && CYC.len != bus_sizer_pkg::LEN_BYTE && !CYC.addr[0])
        |-> (CYC.data[7:0] == wbuf[23:16]);
  endproperty
  a_lane_lo: assert property (p_lane_lo) else $error("byte 1 not on lower lane");
endmodule

// file: test/port_model.sv
// Partner model: external 8-bit or 16-bit port answering bus cycles
// Assumes CYC stands until the cycle ends; acks go back to wait between cycles
`timescale 1ns/1ps
module port_model (
  input  wire logic                clk,
  input  wire bus_sizer_pkg::cyc_t cyc,
  input  wire logic                port16,
  input  wire logic                rsvd,
  input  wire logic [1:0]          lag,
  output logic                     ack_hi,
  output logic                     ack_lo,
  output logic [15:0]              data_in
);
  logic [7:0]          mem [0:255];
  bus_sizer_pkg::cyc_t cur;
  logic [7:0]          x;
  int                  n;
  initial begin
    for (n = 0; n < 256; n++) mem[n] = 8'(n * 37 + 5);
    {ack_hi, ack_lo} = 2'b11;
    data_in = 16'h5a5a;
    forever begin
      @(posedge clk);
      if (cyc.strobe) begin
        cur = cyc;
        x = cur.addr[7:0];
        repeat (lag) @(posedge clk);
        {ack_hi, ack_lo} <= rsvd ? 2'b00 : (port16 ? 2'b01 : 2'b10);
        if (!cur.write) begin
          data_in <= port16 ? {mem[x & 8'hfe], mem[x | 8'h01]} : {mem[x], ~data_in[7:0]};
        end else if (!port16 || cur.len == bus_sizer_pkg::LEN_BYTE) begin
          mem[x] = (port16 && x[0]) ? cur.data[7:0] : cur.data[15:8];
        end else begin
          mem[x & 8'hfe] = cur.data[15:8];
          mem[x | 8'h01] = cur.data[7:0];
        end
        for (n = 0; n < 4000 && cyc.strobe && cyc == cur; n++) @(posedge clk);
        {ack_hi, ack_lo} <= 2'b11;
        data_in <= ~data_in;
        // Hold wait long enough for the synchroniser to see it
        repeat (2) @(posedge clk);
      end
    end
  end
endmodule

// file: test/tb_top.sv
// Testbench: random operands through the sizer, checked against a lane model
// Assumes port_model answers each cycle; one operand at a time
`timescale 1ns/1ps
module tb_top;
  logic                ref_clk = 0;
  logic                nrst = 0;
  logic                req_valid = 0;
  bus_sizer_pkg::req_t req = '0;
  logic                req_ready, done, err_rsvd, err_mis, data_oe, ack_hi, ack_lo;
  logic [31:0]         rdata;
  logic [15:0]         data_in;
  bus_sizer_pkg::cyc_t cyc, prev;
  logic                port16 = 0;
  logic                rsvd = 0;
  logic [1:0]          lag = 0;
  logic [31:0]         seed = 32'h4d49;
  int                  failures = 0;
  int                  comparisons = 0;
  bus_sizer_pkg::cyc_t expq [$];
  always #2.5 ref_clk = ~ref_clk;
  bus_sizer uut (.REF_CLK(ref_clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .DONE(done), .ERR_ACK_RSVD(err_rsvd), .ERR_MISALIGN(err_mis), .RDATA(rdata), .ACK_SIZE_HI(ack_hi),
    .ACK_SIZE_LO(ack_lo), .CYC(cyc), .DATA_IN(data_in), .DATA_OE(data_oe));
  port_model u_port (.clk(ref_clk), .cyc(cyc), .port16(port16), .rsvd(rsvd), .lag(lag), .ack_hi(ack_hi),
    .ack_lo(ack_lo), .data_in(data_in));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("counts: comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycle monitor against the expected cycle list
  always @(posedge ref_clk) begin
    if (cyc.strobe && (!prev.strobe || cyc.addr != prev.addr || cyc.len != prev.len)) begin
      if (expq.size() == 0) chk(1, 0);
      else begin
        chk({cyc.write, cyc.len, cyc.addr}, {expq[0].write, expq[0].len, expq[0].addr});
        if (expq[0].write) chk(cyc.data, expq[0].data);
        chk(data_oe, expq[0].write);
        void'(expq.pop_front());
      end
    end
    prev <= cyc;
  end
  task automatic op(input logic w, input int nb, input logic [23:0] a, input int pw, input logic [31:0] d);
    logic [7:0]          b [4];
    int                  r, k, t, ea, em, nc;
    logic [23:0]         x;
    logic                mis;
    logic [31:0]         rd;
    bus_sizer_pkg::cyc_t e;
    bus_sizer_pkg::len_t lc;
    rd = 0;
    for (k = 0; k < nb; k++) begin
      b[k] = w ? d[8*(nb-1-k) +: 8] : u_port.mem[8'(a + k)];
      rd = {rd[23:0], b[k]};
    end
    mis = nb > 1 && a[0];
    r = nb;
    x = a;
    k = 0;
    nc = 0;
    while (!mis && r > 0) begin
      e = '0;
      e.strobe = 1;
      e.write = w;
      e.addr = x;
      e.len = r == 4 ? bus_sizer_pkg::LEN_LONG : r == 3 ? bus_sizer_pkg::LEN_THREE :
              r == 2 ? bus_sizer_pkg::LEN_WORD : bus_sizer_pkg::LEN_BYTE;
      e.data = (x[0] || r == 1) ? {b[k], b[k]} : {b[k], b[k+1]};
      expq.push_back(e);
      t = (pw == 2 && r >= 2 && !x[0]) ? 2 : 1;
      x += 24'(t);
      r -= t;
      k += t;
      nc++;
    end
    lc = nb == 4 ? bus_sizer_pkg::LEN_LONG : nb == 2 ? bus_sizer_pkg::LEN_WORD : bus_sizer_pkg::LEN_BYTE;
    @(posedge ref_clk);
    req_valid <= 1;
    req <= {w, lc, a, d};
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 0;
    ea = 0;
    em = 0;
    for (t = 0; t < 3000; t++) begin
      @(posedge ref_clk);
      ea += int'(err_rsvd === 1'b1);
      em += int'(err_mis === 1'b1);
      if (done === 1'b1) break;
    end
    chk(done, 1);
    chk(em, mis);
    chk(ea, rsvd ? nc : 0);
    if (!w && !mis) chk(rdata, rd);
    for (k = 0; w && !mis && k < nb; k++) chk(u_port.mem[8'(a + k)], b[k]);
    chk(expq.size(), 0);
    expq.delete();
    $display("test end: write %0d bytes %0d addr %h port %0d", w, nb, a, pw * 8);
  endtask
  initial begin
    int          i, nb, pw;
    logic [23:0] a;
    repeat (5) @(posedge ref_clk);
    nrst <= 1;
    for (i = 0; i < 24; i++) begin
      pw = (i % 12) < 6 ? 1 : 2;
      nb = (i / 2) % 3 == 0 ? 1 : (i / 2) % 3 == 1 ? 2 : 4;
      a = 24'(rnd());
      a[0] = nb == 1 ? i[0] ^ i[2] : 1'b0;
      port16 <= pw == 2;
      lag <= 2'(rnd());
      op(i[0], nb, a, pw, rnd());
    end
    op(0, 2, 24'h000131, 2, 0);
    op(1, 4, 24'h000203, 2, rnd());
    rsvd <= 1;
    port16 <= 1;
    op(0, 4, 24'h000344, 2, 0);
    rsvd <= 0;
    summarize();
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule
